// ==== hw/uirq_top.sv ====
// apb register front end and interrupt request of the usb enable masks
// Contract
// - Each of out endpoints 1 to 3 has an enable bit; 0 blocks, 1 passes.
// - Upper four bits of the out enable register read 0, writes ignored.
// - Bits 7 to 4 of the common enable register read 0, writes ignored.
// - Common enable bit 3 gates the start-of-frame interrupt.
// - Common enable bit 2 gates the bus reset interrupt.
// - Common enable bit 1 gates the bus resume interrupt.
// - Common enable bit 0 gates the bus suspend interrupt.
`timescale 1ns/1ns
`default_nettype none
module uirq_top #(
	parameter logic [7:0] OUT_EN_RST = uirq_pkg::UIRQ_OUT_EN_RST
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [uirq_pkg::UIRQ_AW-1:0] paddr,
	input wire logic [uirq_pkg::UIRQ_DW-1:0] pwdata,
	output logic [uirq_pkg::UIRQ_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// usb events, one-cycle pulses
	input wire logic evt_frame_start,
	input wire logic evt_bus_reset,
	input wire logic evt_bus_resume,
	input wire logic evt_bus_suspend,
	input wire logic [3:1] evt_out_ep,
	// processor interrupt request
	output logic irq_req
);
	import uirq_pkg::*;

	logic [3:0] common_usb_irq_enable_q;
	logic [3:1] out_endpoint_irq_enable_q;
	logic [UIRQ_DW-1:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic wr_go;
	logic acc_wait;
	logic acc_done;
	logic cmn_en_wr;
	logic out_en_wr;
	logic [3:0] cmn_wr_d;
	logic [3:1] out_wr_d;
	logic [UIRQ_NSRC-1:0] evt_vec;
	logic [UIRQ_NSRC-1:0] en_vec;
	logic [UIRQ_NSRC-1:0] clr_vec;
	logic [5:0] idx;
	logic [7:0] wbyte;
	logic [UIRQ_DW-1:0] rd_d;
	logic rd_err_d;

	uirq_flag_if #(.N(UIRQ_NSRC)) fif ();

	uirq_flag_bank #(.N(UIRQ_NSRC)) u_bank (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.fb(fif.bank)
	);

	// word-aligned decode; low two address bits ignored
	function automatic logic mapped(input logic [5:0] i);
		case (i)
			UIRQ_IDX_CMN_EN, UIRQ_IDX_OUT_EN,
			UIRQ_IDX_CMN_FLAG, UIRQ_IDX_OUT_FLAG: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	endfunction

	// write strobe for one register index
	function automatic logic reg_hit(input logic go, input logic [5:0] i,
		input logic [5:0] r);
		reg_hit = go && (i == r);
	endfunction

	assign idx = paddr[7:2];
	assign wbyte = pwdata[7:0];
	// wait state: access seen, answer not yet given
	assign acc_wait = psel && penable && !pready_q;
	// second access cycle is the completing edge
	assign acc_done = psel && penable && pready_q;
	assign wr_go = acc_done && pwrite;
	assign cmn_en_wr = reg_hit(wr_go, idx, UIRQ_IDX_CMN_EN);
	assign out_en_wr = reg_hit(wr_go, idx, UIRQ_IDX_OUT_EN);
	// only the stored fields survive a write
	assign cmn_wr_d = wbyte[3:0] & UIRQ_CMN_MASK[3:0];
	assign out_wr_d = wbyte[3:1] & UIRQ_OUT_MASK[3:1];

	// apb handshake: one wait state, then pready for one cycle
	// fixed wait state lets read data leave a flop
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= acc_wait;
		end
	end

	always_comb begin
		rd_d = UIRQ_RD_IDLE;
		rd_err_d = !mapped(idx);
		case (idx)
			UIRQ_IDX_CMN_EN: begin
				rd_d[3:0] = common_usb_irq_enable_q;
			end
			UIRQ_IDX_OUT_EN: begin
				rd_d[3:1] = out_endpoint_irq_enable_q;
			end
			UIRQ_IDX_CMN_FLAG: begin
				rd_d[3:0] = fif.flags[3:0];
			end
			UIRQ_IDX_OUT_FLAG: begin
				rd_d[3:1] = fif.flags[6:4];
			end
			default: begin
				rd_d = UIRQ_RD_IDLE;
			end
		endcase
	end

	// read data captured in the wait state, zero otherwise
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_q <= UIRQ_RD_IDLE;
		end else if (acc_wait && !pwrite) begin
			prdata_q <= rd_d;
		end else begin
			prdata_q <= UIRQ_RD_IDLE;
		end
	end

	// refusal flag rides with pready for reads and writes alike
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pslverr_q <= 1'b0;
		end else if (acc_wait) begin
			pslverr_q <= rd_err_d;
		end else begin
			pslverr_q <= 1'b0;
		end
	end

	// common enables; bits 7..4 are not stored
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			common_usb_irq_enable_q <= UIRQ_CMN_EN_RST[3:0];
		end else if (cmn_en_wr) begin
			common_usb_irq_enable_q <= cmn_wr_d;
		end
	end

	// out endpoint enables; upper nibble and bit 0 dropped
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			out_endpoint_irq_enable_q <= OUT_EN_RST[3:1];
		end else if (out_en_wr) begin
			out_endpoint_irq_enable_q <= out_wr_d;
		end
	end

	// flag bank wiring: bits 3..0 common, 6..4 out endpoints 1..3
	always_comb begin
		evt_vec = {UIRQ_NSRC{1'b0}};
		evt_vec[UIRQ_SOF_BIT] = evt_frame_start;
		evt_vec[UIRQ_BRST_BIT] = evt_bus_reset;
		evt_vec[UIRQ_RSUM_BIT] = evt_bus_resume;
		evt_vec[UIRQ_SUSP_BIT] = evt_bus_suspend;
		evt_vec[6:4] = evt_out_ep;
	end

	// enables line up with the sources, one for one
	always_comb begin
		en_vec = {UIRQ_NSRC{1'b0}};
		en_vec[UIRQ_SOF_BIT] =
			common_usb_irq_enable_q[UIRQ_SOF_BIT];
		en_vec[UIRQ_BRST_BIT] =
			common_usb_irq_enable_q[UIRQ_BRST_BIT];
		en_vec[UIRQ_RSUM_BIT] =
			common_usb_irq_enable_q[UIRQ_RSUM_BIT];
		en_vec[UIRQ_SUSP_BIT] =
			common_usb_irq_enable_q[UIRQ_SUSP_BIT];
		en_vec[6:4] = out_endpoint_irq_enable_q;
	end

	// write one to clear; a same-cycle event keeps the flag set
	always_comb begin
		clr_vec = {UIRQ_NSRC{1'b0}};
		if (reg_hit(wr_go, idx, UIRQ_IDX_CMN_FLAG)) begin
			clr_vec[3:0] = cmn_wr_d;
		end
		if (reg_hit(wr_go, idx, UIRQ_IDX_OUT_FLAG)) begin
			clr_vec[6:4] = out_wr_d;
		end
	end

	assign fif.evt = evt_vec;
	assign fif.en = en_vec;
	assign fif.clr = clr_vec;

	// registered request, one cycle behind the flags
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= fif.pend;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq_req = irq_q;
endmodule
`default_nettype wire

// ==== hw/uirq_pkg.sv ====
// constants of the usb interrupt enable mask block
package uirq_pkg;
	localparam int unsigned UIRQ_AW = 8;
	localparam int unsigned UIRQ_DW = 32;
	localparam int unsigned UIRQ_NSRC = 7;
	// register indexes; byte address is four times the index
	localparam logic [5:0] UIRQ_IDX_CMN_FLAG = 6'h02;
	localparam logic [5:0] UIRQ_IDX_OUT_FLAG = 6'h04;
	localparam logic [5:0] UIRQ_IDX_OUT_EN = 6'h09;
	localparam logic [5:0] UIRQ_IDX_CMN_EN = 6'h0b;
	// common enable fields
	localparam int unsigned UIRQ_SUSP_BIT = 0;
	localparam int unsigned UIRQ_RSUM_BIT = 1;
	localparam int unsigned UIRQ_BRST_BIT = 2;
	localparam int unsigned UIRQ_SOF_BIT = 3;
	localparam logic [7:0] UIRQ_CMN_MASK = 8'h0f;
	// out endpoint enable fields, bit n for endpoint n
	localparam int unsigned UIRQ_OUT1_BIT = 1;
	localparam int unsigned UIRQ_OUT3_BIT = 3;
	localparam logic [7:0] UIRQ_OUT_MASK = 8'h0e;
	// reset values
	localparam logic [7:0] UIRQ_CMN_EN_RST = 8'h06;
	localparam logic [7:0] UIRQ_OUT_EN_RST = 8'h00;
	localparam logic [31:0] UIRQ_RD_IDLE = 32'h0000_0000;
endpackage

// ==== hw/uirq_flag_if.sv ====
// carrier between the register front end and the sticky flag bank
`timescale 1ns/1ns
`default_nettype none
interface uirq_flag_if #(parameter int unsigned N = 7);
	logic [N-1:0] evt;
	logic [N-1:0] clr;
	logic [N-1:0] en;
	logic [N-1:0] flags;
	logic pend;
	modport ctrl (output evt, output clr, output en, input flags, input pend);
	modport bank (input evt, input clr, input en, output flags, output pend);
endinterface
`default_nettype wire

// ==== hw/uirq_flag_bank.sv ====
// sticky event flags with enable gating into one pending level
`timescale 1ns/1ns
`default_nettype none
module uirq_flag_bank #(
	parameter int unsigned N = 7
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// flag traffic
	uirq_flag_if.bank fb
);
	logic [N-1:0] flag_q;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			// set beats clear; disabled sources still record
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					flag_q[i] <= 1'b0;
				end else if (fb.evt[i]) begin
					flag_q[i] <= 1'b1;
				end else if (fb.clr[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign fb.flags = flag_q;
	assign fb.pend = |(flag_q & fb.en);
endmodule
`default_nettype wire

// ==== test/uirq_properties.sv ====
// port assertions of the usb enable mask block
`timescale 1ns/1ns
`default_nettype none
module uirq_properties (
	// watched ports
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic evt_frame_start,
	input wire logic evt_bus_reset,
	input wire logic evt_bus_resume,
	input wire logic evt_bus_suspend,
	input wire logic [3:1] evt_out_ep,
	input wire logic irq_req
);
	import uirq_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [5:0] ix;
	logic ev;
	logic wd;
	logic map;
	assign ix = paddr[7:2];
	assign ev = evt_frame_start | evt_bus_reset | evt_bus_resume
		| evt_bus_suspend | (|evt_out_ep);
	assign wd = pready && pwrite;
	assign map = ix inside {UIRQ_IDX_CMN_FLAG, UIRQ_IDX_OUT_FLAG,
		UIRQ_IDX_OUT_EN, UIRQ_IDX_CMN_EN};
	property p_wait; psel && $rose(penable) |=> pready; endproperty
	a_wait: assert property (p_wait) else $error("no ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_zero; !pready |-> prdata == 32'h0; endproperty
	a_zero: assert property (p_zero) else $error("stale read data");
	property p_cmn; pready && !pwrite && ix == UIRQ_IDX_CMN_EN
		|-> prdata[31:4] == 28'h0; endproperty
	a_cmn: assert property (p_cmn) else $error("common high bits");
	property p_out; pready && !pwrite && ix == UIRQ_IDX_OUT_EN
		|-> prdata[31:4] == 28'h0 && !prdata[0]; endproperty
	a_out: assert property (p_out) else $error("out spare bits");
	property p_err; pready && !map |-> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
	property p_irq; $rose(irq_req) |-> $past(ev, 2) || $past(wd, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");
	property p_fall; $fell(irq_req) |-> $past(wd, 2); endproperty
	a_fall: assert property (p_fall) else $error("irq dropped");
endmodule
bind uirq_top uirq_properties u_prop (.sys_clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
	.evt_frame_start, .evt_bus_reset, .evt_bus_resume,
	.evt_bus_suspend, .evt_out_ep, .irq_req);
`default_nettype wire

// ==== test/uirq_fw_model.sv ====
// firmware side apb master model
`timescale 1ns/1ns
`default_nettype none
module uirq_fw_model (
	// apb
	input wire logic sys_clk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// request held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [5:0] i,
		input logic [7:0] d, output logic [31:0] rd, output logic er);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// testbench of the usb enable mask block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import uirq_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq_req, er;
	logic [7:0] paddr, m;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0] en, fl;
	logic [6:0] ev = 7'h00;
	int n_mismatch = 0;
	int compares = 0;
	always #5 sys_clk = ~sys_clk;
	uirq_fw_model fw (.sys_clk, .prdata, .pready, .pslverr, .psel,
		.penable, .pwrite, .paddr, .pwdata);
	uirq_top dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .evt_frame_start(ev[3]),
		.evt_bus_reset(ev[2]), .evt_bus_resume(ev[1]),
		.evt_bus_suspend(ev[0]), .evt_out_ep(ev[6:4]), .irq_req);
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wr(logic [5:0] i, logic [7:0] d);
		fw.xfer(1'b1, i, d, rd, er);
	endtask
	task automatic rdc(logic [5:0] i, logic [31:0] e);
		fw.xfer(1'b0, i, 8'h00, rd, er);
		chk("rdata", e, rd);
	endtask
	task automatic test_done;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rdc(UIRQ_IDX_CMN_EN, 32'h06);
		rdc(UIRQ_IDX_OUT_EN, 32'h00);
		wr(UIRQ_IDX_CMN_EN, 8'hff);
		rdc(UIRQ_IDX_CMN_EN, 32'h0f);
		wr(UIRQ_IDX_OUT_EN, 8'hff);
		rdc(UIRQ_IDX_OUT_EN, 32'h0e);
		rdc(6'h3f, 32'h00);
		chk("slverr", 32'h1, {31'h0, er});
		wr(6'h3f, 8'hff);
		chk("wr_slverr", 32'h1, {31'h0, er});
		wr(UIRQ_IDX_CMN_EN, 8'h00);
		wr(UIRQ_IDX_OUT_EN, 8'h00);
		// sources 0..3 common, 4..6 out endpoints 1..3
		for (int i = 0; i < 7; i++) begin
			m = (i < 4) ? 8'h01 << i : 8'h01 << (i - 3);
			en = (i < 4) ? UIRQ_IDX_CMN_EN : UIRQ_IDX_OUT_EN;
			fl = (i < 4) ? UIRQ_IDX_CMN_FLAG : UIRQ_IDX_OUT_FLAG;
			ev[i] <= 1'b1;
			@(posedge sys_clk);
			ev[i] <= 1'b0;
			repeat (3) @(posedge sys_clk);
			chk("irq_off", 32'h0, {31'h0, irq_req});
			rdc(fl, {24'h0, m});
			wr(en, m);
			repeat (3) @(posedge sys_clk);
			chk("irq_on", 32'h1, {31'h0, irq_req});
			wr(fl, m);
			repeat (3) @(posedge sys_clk);
			chk("irq_clr", 32'h0, {31'h0, irq_req});
			wr(en, 8'h00);
		end
		// enabled source: request follows the flag by one edge
		wr(UIRQ_IDX_CMN_EN, 8'h01);
		ev[0] <= 1'b1;
		@(posedge sys_clk);
		ev[0] <= 1'b0;
		@(negedge sys_clk);
		chk("irq_early", 32'h0, {31'h0, irq_req});
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk("irq_evt", 32'h1, {31'h0, irq_req});
		// reset in mid-run clears flags and request, restores enables
		@(posedge sys_clk);
		resetn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk("irq_rst", 32'h0, {31'h0, irq_req});
		resetn <= 1'b1;
		rdc(UIRQ_IDX_CMN_EN, 32'h06);
		rdc(UIRQ_IDX_CMN_FLAG, 32'h00);
		test_done();
	end
endmodule
`default_nettype wire
